//--- hw/adc_capture_pkg.sv
package adc_capture_pkg;

   // ----------------------------------------
   // converter data
   // ----------------------------------------
   localparam int NUM_CH = 8;
   localparam int SAMPLE_W = 14;
   localparam int EXT_W = 16;
   localparam int GROUP_SIZE = 4;
   localparam logic [SAMPLE_W-1:0] OB_ZERO = 14'h2000;
   localparam logic [SAMPLE_W-1:0] OB_POS_FS = 14'h3fff;
   localparam logic [SAMPLE_W-1:0] OB_NEG_FS = 14'h0000;
   localparam logic [SAMPLE_W-1:0] TC_POS_FS = 14'h1fff;
   localparam logic [SAMPLE_W-1:0] TC_NEG_FS = 14'h2000;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int HCLK_MHZ = 25;
   localparam int RATE_MIN_MSPS = 1;
   localparam int RATE_MAX_MSPS = 105;
   localparam int NAP_SETTLE_CYC = 100;
   localparam int DCS_LOCK_CYC = 100;
   localparam int CLK_RESTART_CYC = 4000;
   localparam int SLEEP_SETTLE_MS = 2;
   localparam int SLEEP_SETTLE_SAMPLES = 2000;
   // clock loss: no edge within one slowest sample period, rounded down, at least one cycle
   localparam int LOSS_NS = 1000 / RATE_MIN_MSPS;
   localparam int LOSS_CYC_RAW = LOSS_NS * HCLK_MHZ / 1000;
   localparam int LOSS_CYC = (LOSS_CYC_RAW < 1) ? 1 : LOSS_CYC_RAW;
   localparam int LOSS_W = 8;
   localparam int SETTLE_W = 16;
   localparam int CLKDIV_W = 8;

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_CLKDIV = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFF_SAMPLE0 = 8'h20;
   localparam logic [7:0] OFF_SAMPLE7 = 8'h3c;

   // ctrl field positions: per channel byte lane
   localparam int CTRL_OE_B = 0;
   localparam int CTRL_SHDN_B = 1;
   localparam int CTRL_NAP_B = 2;
   localparam int CTRL_DCS_B = 4;
   localparam int CTRL_TC_B = 5;
   // clock divider register fields, counted from above the divider value
   localparam int MODE_CLKOUT_EN_B = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [CLKDIV_W-1:0] CLKDIV_RESET = 8'h02;

   // status field positions
   localparam int ST_VALID_LSB = 0;
   localparam int ST_LOSS_LSB = 8;
   localparam int ST_OVF_LSB = 16;

   // irq bits: per channel overflow and valid-drop
   localparam int IRQ_OVF_LSB = 0;
   localparam int IRQ_DROP_LSB = 8;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // per channel control toward the configuration controller
   typedef struct packed {
      logic oe;
      logic shutdown;
      logic nap;
      logic dcs;
      logic twos_comp;
   } chan_cfg_s;

   // captured per-channel sample
   typedef struct packed {
      logic valid;
      logic ovf;
      logic [EXT_W-1:0] data;
   } chan_sample_s;

endpackage

//--- hw/adc_sample_capture.sv
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// - generated sample clock stays between 1 and 105 Msps
// - every sample is sign-extended before going downstream
// - after nap, wait about 100 sample clocks before trusting data
// - after sleep, discard samples for the millisecond reference recharge
// - after the sample clock stops and restarts, wait about 4000 cycles
// - stabilizer on: generated clock duty cycle between 40 and 60 percent
// - stabilizer on after long clock stop: wait about 100 cycles to lock
// - stabilizer off: generated clock duty cycle 50 percent within 5 percent
// - converter settings go out through the configuration controller only
// - two generated clocks: first for converters 0-3, second for 4-7
module adc_sample_capture (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // converter data pins
   input wire logic [adc_capture_pkg::NUM_CH*adc_capture_pkg::SAMPLE_W-1:0] adc_data,
   input wire logic [adc_capture_pkg::NUM_CH-1:0] overflow_flag,
   // sample clocks
   output logic user_sample_clock_out_a,
   output logic user_sample_clock_out_b,
   input wire logic sample_clock_return_a,
   input wire logic sample_clock_return_b,
   // settings toward the configuration controller
   output adc_capture_pkg::chan_cfg_s [adc_capture_pkg::NUM_CH-1:0] chan_cfg,
   // downstream samples
   output adc_capture_pkg::chan_sample_s [adc_capture_pkg::NUM_CH-1:0] samples,
   output logic [adc_capture_pkg::NUM_CH-1:0] sample_strobe,
   // interrupt
   output logic irq
);
   import adc_capture_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [31:0] ctrl_lo_reg, ctrl_hi_reg;
   logic [NUM_CH-1:0] nap_reg;
   logic clkout_en_reg;
   logic [CLKDIV_W-1:0] clkdiv_reg;
   logic [31:0] irq_stat_reg, irq_mask_reg;
   logic [31:0] irq_set;
   logic [31:0] w1c;
   logic [31:0] status;

   // bus address phase capture
   logic wr_pend_reg;
   logic [7:0] addr_reg;
   logic [31:0] rdata_next;

   // clocks
   logic [CLKDIV_W-1:0] div_cnt_reg;
   logic clkgen_reg;
   logic [1:0] ret_meta_reg, ret_sync_reg, ret_prev_reg;
   logic [1:0] ret_rise;

   logic [NUM_CH-1:0] lost, drop;

   // largest half period in hclk cycles that keeps the generated clock at the minimum rate
   localparam int DIV_MAX = HCLK_MHZ / (2 * RATE_MIN_MSPS);

   // byte lane of a channel inside the two control words
   function automatic logic [7:0] ctrl_byte(input int ch, input logic [31:0] lo, input logic [31:0] hi);
      logic [63:0] all;
      all = {hi, lo};
      return all[ch*8 +: 8];
   endfunction

   // ------------------------------------------------------------
   // ahb-lite slave: zero wait states, always okay
   // ------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= '0;
      end else if (hready) begin
         wr_pend_reg <= hsel && hwrite && htrans == HTRANS_NONSEQ;
         addr_reg <= haddr;
      end
   end

   // write side effects: control words, mode, divider, mask
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_lo_reg <= CTRL_RESET;
         ctrl_hi_reg <= CTRL_RESET;
         clkout_en_reg <= 1'b0;
         clkdiv_reg <= CLKDIV_RESET;
         irq_mask_reg <= '0;
      end else if (wr_pend_reg) begin
         case (addr_reg)
            OFF_CTRL: ctrl_lo_reg <= hwdata;
            OFF_MODE: ctrl_hi_reg <= hwdata;
            OFF_CLKDIV: begin
               clkout_en_reg <= hwdata[MODE_CLKOUT_EN_B + CLKDIV_W];
               // a zero divider would wrap to 256 cycles per half period, a large one would run the clock below the minimum rate
               if (hwdata[CLKDIV_W-1:0] == '0)
                  clkdiv_reg <= CLKDIV_RESET;
               else if (hwdata[CLKDIV_W-1:0] > CLKDIV_W'(DIV_MAX))
                  clkdiv_reg <= CLKDIV_W'(DIV_MAX);
               else
                  clkdiv_reg <= hwdata[CLKDIV_W-1:0];
            end
            OFF_IRQ_MASK: irq_mask_reg <= hwdata;
            default: ;
         endcase
      end
   end

   // per channel settings; shutdown unless enabled, matching the controller reset state
   always_comb begin
      logic [7:0] lane;
      lane = '0;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         lane = ctrl_byte(ch, ctrl_lo_reg, ctrl_hi_reg);
         chan_cfg[ch].oe = lane[CTRL_OE_B];
         chan_cfg[ch].shutdown = !lane[CTRL_SHDN_B];
         chan_cfg[ch].nap = lane[CTRL_NAP_B];
         chan_cfg[ch].dcs = lane[CTRL_DCS_B];
         chan_cfg[ch].twos_comp = lane[CTRL_TC_B];
      end
   end

   // status word built from channel state
   always_comb begin
      status = '0;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         status[ST_VALID_LSB + ch] = samples[ch].valid;
         status[ST_LOSS_LSB + ch] = lost[ch];
         status[ST_OVF_LSB + ch] = samples[ch].ovf;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = '0;
      case (haddr)
         OFF_CTRL: rdata_next = ctrl_lo_reg;
         OFF_MODE: rdata_next = ctrl_hi_reg;
         OFF_CLKDIV: rdata_next = {23'h000000, clkout_en_reg, clkdiv_reg};
         OFF_STATUS: rdata_next = status;
         OFF_IRQ_STAT: rdata_next = irq_stat_reg;
         OFF_IRQ_MASK: rdata_next = irq_mask_reg;
         default: begin
            if (haddr >= OFF_SAMPLE0 && haddr <= OFF_SAMPLE7)
               rdata_next = {14'h0000, samples[haddr[4:2]]};
         end
      endcase
   end

   // read data registered into the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (hready && hsel && !hwrite && htrans == HTRANS_NONSEQ) begin
         hrdata <= rdata_next;
      end
   end

   // ------------------------------------------------------------
   // interrupts: sticky, write one to clear, set wins
   // ------------------------------------------------------------
   always_comb begin
      irq_set = '0;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         irq_set[IRQ_OVF_LSB + ch] = sample_strobe[ch] && samples[ch].ovf;
         irq_set[IRQ_DROP_LSB + ch] = drop[ch];
      end
      w1c = (wr_pend_reg && addr_reg == OFF_IRQ_STAT) ? hwdata : '0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~w1c) | irq_set;
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ------------------------------------------------------------
   // generated sample clocks: divider of hclk, both groups share it
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_reg <= '0;
         clkgen_reg <= 1'b0;
      end else if (!clkout_en_reg) begin
         div_cnt_reg <= '0;
         clkgen_reg <= 1'b0;
      end else if (div_cnt_reg >= clkdiv_reg - 1'b1) begin
         div_cnt_reg <= '0;
         clkgen_reg <= !clkgen_reg;
      end else begin
         div_cnt_reg <= div_cnt_reg + 1'b1;
      end
   end

   assign user_sample_clock_out_a = clkgen_reg;
   assign user_sample_clock_out_b = clkgen_reg;

   // ------------------------------------------------------------
   // returned clocks: synchronise and find rising edges
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ret_meta_reg <= '0;
         ret_sync_reg <= '0;
         ret_prev_reg <= '0;
      end else begin
         ret_meta_reg <= {sample_clock_return_b, sample_clock_return_a};
         ret_sync_reg <= ret_meta_reg;
         ret_prev_reg <= ret_sync_reg;
      end
   end

   assign ret_rise = ret_sync_reg & ~ret_prev_reg;

   // ------------------------------------------------------------
   // channels
   // ------------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      chan_settle u_chan (
         .hclk(hclk),
         .hresetn(hresetn),
         .cfg(chan_cfg[ch]),
         .clk_rise(ret_rise[ch / GROUP_SIZE]),
         .adc_data(adc_data[ch*SAMPLE_W +: SAMPLE_W]),
         .adc_ovf(overflow_flag[ch]),
         .sample(samples[ch]),
         .clk_lost(lost[ch]),
         .valid_drop(drop[ch])
      );

      // strobe one cycle after each captured edge
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn)
            sample_strobe[ch] <= 1'b0;
         else
            sample_strobe[ch] <= ret_rise[ch / GROUP_SIZE];
      end
   end

endmodule // adc_sample_capture

//--- hw/chan_settle.sv
`timescale 1ns/1ps
// one channel: input sync of data and overflow pins, clock loss, settling count, capture
module chan_settle (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // configuration
   input wire adc_capture_pkg::chan_cfg_s cfg,
   // converter pins
   input wire logic clk_rise,
   input wire logic [adc_capture_pkg::SAMPLE_W-1:0] adc_data,
   input wire logic adc_ovf,
   // results
   output adc_capture_pkg::chan_sample_s sample,
   output logic clk_lost,
   output logic valid_drop
);
   import adc_capture_pkg::*;

   logic [SAMPLE_W-1:0] d_meta_reg, d_sync_reg;
   logic o_meta_reg, o_sync_reg;
   logic [LOSS_W-1:0] loss_cnt_reg;
   logic [SETTLE_W-1:0] settle_reg;
   logic shdn_reg, loss_reg, lost_reg, valid_reg;
   logic [SETTLE_W-1:0] need;

   // sign extend a sample to the downstream width
   function automatic logic [EXT_W-1:0] sext(input logic [SAMPLE_W-1:0] s, input logic tc);
      logic [SAMPLE_W-1:0] v;
      v = tc ? s : (s ^ OB_ZERO); // offset binary to two's complement
      return {{(EXT_W-SAMPLE_W){v[SAMPLE_W-1]}}, v};
   endfunction

   // -----------------------------------------------
   // pin synchronisers
   // -----------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         d_meta_reg <= '0;
         d_sync_reg <= '0;
         o_meta_reg <= 1'b0;
         o_sync_reg <= 1'b0;
      end else begin
         d_meta_reg <= adc_data;
         d_sync_reg <= d_meta_reg;
         o_meta_reg <= adc_ovf;
         o_sync_reg <= o_meta_reg;
      end
   end

   // clock loss watchdog on the returned sample clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         loss_cnt_reg <= '0;
         lost_reg <= 1'b1;
      end else if (clk_rise) begin
         loss_cnt_reg <= '0;
         lost_reg <= 1'b0;
      end else if (loss_cnt_reg >= LOSS_W'(LOSS_CYC)) begin
         lost_reg <= 1'b1;
      end else begin
         loss_cnt_reg <= loss_cnt_reg + 1'b1;
      end
   end

   // settling length chosen from the event that dropped the flag
   always_comb begin
      need = SETTLE_W'(NAP_SETTLE_CYC);
      if (shdn_reg)
         need = SETTLE_W'(SLEEP_SETTLE_SAMPLES);
      if (loss_reg)
         need = SETTLE_W'(CLK_RESTART_CYC);
      if (cfg.dcs && need < SETTLE_W'(DCS_LOCK_CYC))
         need = SETTLE_W'(DCS_LOCK_CYC);
   end

   // valid flag: drops on power-down or clock loss, rises after settling edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         settle_reg <= '0;
         valid_reg <= 1'b0;
         shdn_reg <= 1'b1;
         loss_reg <= 1'b0;
      end else if (cfg.shutdown || cfg.nap || !cfg.oe || lost_reg) begin
         valid_reg <= 1'b0;
         settle_reg <= '0;
         // causes stay remembered until the flag rises, so the longest recovery applies
         shdn_reg <= shdn_reg || cfg.shutdown;
         loss_reg <= loss_reg || (lost_reg && !cfg.shutdown && !cfg.nap);
      end else if (!valid_reg && clk_rise) begin
         if (settle_reg >= need - 1'b1) begin
            valid_reg <= 1'b1;
            shdn_reg <= 1'b0;
            loss_reg <= 1'b0;
         end else begin
            settle_reg <= settle_reg + 1'b1;
         end
      end
   end

   assign valid_drop = valid_reg && (cfg.shutdown || cfg.nap || !cfg.oe || lost_reg);
   assign clk_lost = lost_reg;

   // capture on each rising sample clock; samples are discarded while invalid
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sample <= '0;
      end else if (clk_rise) begin
         sample.valid <= valid_reg;
         sample.ovf <= valid_reg && o_sync_reg;
         sample.data <= sext(d_sync_reg, cfg.twos_comp);
      end else if (!valid_reg) begin
         // a stopped clock brings no edge, so the flag is dropped here as well
         sample.valid <= 1'b0;
         sample.ovf <= 1'b0;
      end
   end

endmodule // chan_settle

//--- verif/adc_bank_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// eight converters behind one returned clock pair
// ----------------------------------------
module adc_bank_model (
   // settings and stimulus
   input wire adc_capture_pkg::chan_cfg_s [adc_capture_pkg::NUM_CH-1:0] cfg,
   input wire logic run,
   input wire logic signed [15:0] ain,
   // converter pins
   output logic [adc_capture_pkg::NUM_CH*adc_capture_pkg::SAMPLE_W-1:0] adc_data,
   output logic [adc_capture_pkg::NUM_CH-1:0] ovf,
   output logic clk_ret_a,
   output logic clk_ret_b
);
   import adc_capture_pkg::*;
   logic lclk;
   logic signed [15:0] c;
   // 320 ns sample clock, held low while stopped
   initial begin
      lclk = 1'b0;
      adc_data = '0;
      ovf = '0;
      #7;
      forever begin
         #160;
         lclk = run ? ~lclk : 1'b0;
      end
   end
   assign clk_ret_a = lclk;
   assign clk_ret_b = lclk;
   // outputs move on the falling edge, the rising edge is the sampling one
   always @(negedge lclk) begin
      c = (ain > 16'sh1fff) ? 16'sh1fff : (ain < -16'sh2000) ? -16'sh2000 : ain;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         if (cfg[ch].nap || cfg[ch].shutdown || !cfg[ch].oe) begin
            adc_data[ch*SAMPLE_W +: SAMPLE_W] <= ~adc_data[ch*SAMPLE_W +: SAMPLE_W];
            ovf[ch] <= ~ovf[ch];
         end else begin
            adc_data[ch*SAMPLE_W +: SAMPLE_W] <= cfg[ch].twos_comp ? c[13:0] : c[13:0] ^ 14'h2000;
            ovf[ch] <= c != ain;
         end
      end
   end
endmodule // adc_bank_model

//--- verif/adc_sample_capture_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the sample capture block
// ----------------------------------------
module adc_sample_capture_properties (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   // sample clocks
   input wire logic user_sample_clock_out_a,
   input wire logic user_sample_clock_out_b,
   input wire logic sample_clock_return_a,
   // downstream samples
   input wire adc_capture_pkg::chan_sample_s [adc_capture_pkg::NUM_CH-1:0] samples,
   input wire logic [adc_capture_pkg::NUM_CH-1:0] sample_strobe
);
   import adc_capture_pkg::*;
   logic [NUM_CH-1:0] ext_ok;
   logic [NUM_CH-1:0] quiet_ok;
   logic [NUM_CH-1:0] clamp_ok;
   // per channel extension, refusal and clamp relations
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         ext_ok[i] = samples[i].data[15:14] == {2{samples[i].data[13]}};
         quiet_ok[i] = samples[i].valid || !samples[i].ovf;
         clamp_ok[i] = !samples[i].ovf || samples[i].data == 16'h1fff || samples[i].data == 16'he000;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   bus_ready_a: assert property (hreadyout) else $error("bus not ready");
   bus_okay_a: assert property (!hresp) else $error("bus response not okay");
   clock_pair_a: assert property (user_sample_clock_out_a == user_sample_clock_out_b)
      else $error("group clocks differ");
   strobe_pulse_a: assert property ((sample_strobe & $past(sample_strobe)) == 8'h00)
      else $error("strobe longer than one cycle");
   strobe_cause_a: assert property (sample_strobe[0] |-> $past(sample_clock_return_a, 2) ||
      $past(sample_clock_return_a, 3)) else $error("strobe without returned clock edge");
   data_hold_a: assert property (!sample_strobe[0] |-> $stable(samples[0].data))
      else $error("sample changed without strobe");
   sign_ext_a: assert property (ext_ok == 8'hff) else $error("sample not sign extended");
   quiet_ovf_a: assert property (quiet_ok == 8'hff) else $error("overflow on invalid sample");
   ovf_clamp_a: assert property (clamp_ok == 8'hff) else $error("overflow not at full scale");
   // main scenarios
   valid_c: cover property (sample_strobe[0] && samples[0].valid);
   ovf_c: cover property (samples[0].ovf);
   drop_c: cover property ($fell(samples[0].valid));
   clkout_c: cover property ($rose(user_sample_clock_out_a));
endmodule // adc_sample_capture_properties

bind adc_sample_capture adc_sample_capture_properties u_props (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .user_sample_clock_out_a(user_sample_clock_out_a),
   .user_sample_clock_out_b(user_sample_clock_out_b), .sample_clock_return_a(sample_clock_return_a),
   .samples(samples), .sample_strobe(sample_strobe));

//--- verif/adc_sample_capture_tb_top.sv
`timescale 1ns/1ps
module adc_sample_capture_tb_top;
   import adc_capture_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic hclk, hresetn, hsel, hwrite, run, hreadyout, hresp, ck_a, ck_b, ret_a, ret_b, irq;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata;
   logic [NUM_CH*SAMPLE_W-1:0] adc_data;
   logic [NUM_CH-1:0] ovf, sample_strobe;
   logic signed [15:0] ain;
   chan_cfg_s [NUM_CH-1:0] chan_cfg;
   chan_sample_s [NUM_CH-1:0] samples;
   int err_count = 0;
   int tests_run = 0;

   adc_sample_capture u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .adc_data(adc_data), .overflow_flag(ovf),
      .user_sample_clock_out_a(ck_a), .user_sample_clock_out_b(ck_b), .sample_clock_return_a(ret_a),
      .sample_clock_return_b(ret_b), .chan_cfg(chan_cfg), .samples(samples), .sample_strobe(sample_strobe),
      .irq(irq));
   adc_bank_model u_adc (.cfg(chan_cfg), .run(run), .ain(ain), .adc_data(adc_data), .ovf(ovf),
      .clk_ret_a(ret_a), .clk_ret_b(ret_b));

   // 25 MHz bus clock
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // ----------------------------------------
   // bus tasks and compares
   // ----------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      @(negedge hclk); // let the landed write settle before anything looks at it
   endtask
   task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask
   task automatic chk_bit(input string what, input logic e, input logic g);
      chk_word(what, {31'h0, e}, {31'h0, g});
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk_word(what, e, q);
   endtask
   // wait for returned edges, then let capture land
   task automatic edges(input int n);
      repeat (n) @(posedge ret_a);
      repeat (6) @(posedge hclk);
   endtask
   // clamped, sign-extended sample word as software sees it
   function automatic logic [31:0] sreg(input logic signed [15:0] v);
      logic signed [15:0] c;
      c = (v > 16'sh1fff) ? 16'sh1fff : (v < -16'sh2000) ? -16'sh2000 : v;
      sreg = {14'h0, 1'b1, c != v, c};
   endfunction
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] e;
      logic signed [15:0] vals [6];
      realtime t0, t1, t2;
      vals = '{16'sh0000, -16'sh012c, 16'sh1fff, -16'sh2000, 16'sh2400, -16'sh2400};
      {hresetn, hsel, hwrite, run, haddr, htrans, hwdata, ain} = '0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      chk_bit("cfg shutdown", 1'b1, chan_cfg[0].shutdown);
      rd_chk("ctrl reset", OFF_CTRL, CTRL_RESET);
      rd_chk("clkdiv reset", OFF_CLKDIV, 32'h0000_0002);
      rd_chk("unmapped", 8'h18, 32'h0);
      // clock runs first, so waking from shutdown is not taken for a clock loss
      run <= 1'b1;
      edges(2);
      wr(OFF_CTRL, 32'h0303_0303);
      wr(OFF_MODE, 32'h3333_3333);
      chk_bit("cfg run", 1'b0, chan_cfg[0].shutdown);
      chk_bit("cfg dcs", 1'b1, chan_cfg[4].dcs);
      edges(1900);
      chk_bit("valid in sleep settle", 1'b0, samples[0].valid);
      edges(200);
      chk_bit("valid after sleep", 1'b1, samples[0].valid);
      foreach (vals[i]) begin
         ain <= vals[i];
         edges(4);
         e = sreg(vals[i]);
         rd_chk("sample ch0", OFF_SAMPLE0, e);
         rd_chk("sample ch7", OFF_SAMPLE7, e);
         chk_word("strobe data", e, {14'h0, samples[3].valid, samples[3].ovf, samples[3].data});
      end
      ain <= 16'sh0000;
      edges(4);
      rd_chk("irq ovf seen", OFF_IRQ_STAT, 32'h0000_00ff);
      chk_bit("irq masked", 1'b0, irq);
      wr(OFF_IRQ_MASK, 32'h0000_00ff);
      chk_bit("irq raised", 1'b1, irq);
      wr(OFF_IRQ_STAT, 32'h0000_00ff);
      chk_bit("irq cleared", 1'b0, irq);
      wr(OFF_CTRL, 32'h0303_0307);
      edges(4);
      rd_chk("status nap", OFF_STATUS, 32'h0000_00fe);
      rd_chk("irq drop", OFF_IRQ_STAT, 32'h0000_0100);
      chk_bit("drop masked", 1'b0, irq);
      wr(OFF_CTRL, 32'h0303_0303);
      edges(90);
      chk_bit("valid in nap settle", 1'b0, samples[0].valid);
      edges(20);
      chk_bit("valid after nap", 1'b1, samples[0].valid);
      run <= 1'b0;
      repeat (100) @(posedge hclk);
      rd_chk("status loss", OFF_STATUS, 32'h0000_ff00);
      run <= 1'b1;
      edges(3900);
      chk_bit("valid in restart ch7", 1'b0, samples[7].valid);
      edges(200);
      chk_bit("valid after restart ch7", 1'b1, samples[7].valid);
      rd_chk("status restart", OFF_STATUS, 32'h0000_00ff);
      wr(OFF_CLKDIV, 32'h0000_0103);
      @(posedge ck_a);
      t0 = $realtime;
      @(negedge ck_a);
      t1 = $realtime;
      @(posedge ck_a);
      t2 = $realtime;
      chk_word("clock high ns", 32'd120, 32'(int'(t1 - t0)));
      chk_word("clock low ns", 32'd120, 32'(int'(t2 - t1)));
      // 1 Msps at 25 MHz allows at most 12 hclk cycles per half period
      wr(OFF_CLKDIV, 32'h0000_01ff);
      rd_chk("clkdiv clamp", OFF_CLKDIV, 32'h0000_010c);
      complete_run();
   end
   // cut a hang short
   initial begin
      repeat (90000) @(posedge hclk);
      err_count++;
      $display("unexpected watchdog: expected end of tests, seen timeout");
      complete_run();
   end
endmodule // adc_sample_capture_tb_top
